// ===== sas_pkg.sv
// Constants, types and register map of the 12-bit SAR converter sequencer.
// Assumes one 125 MHz clock that also serves as the converter oscillator.
// Behaviour
// - Reference field sits at bits five to four.
// - Reference codes pick supply or external references.
// - Pin field turns inputs digital from the top.
// - Acquisition field maps to zero to twenty periods.
// - Clock field picks oscillator divider or RC clock.
// - RC clock starts one instruction cycle late.
// - Reset restores registers and abandons any conversion.
// - Completion loads result, clears start, sets flag.
// - Programmed acquisition runs, then conversion starts itself.
// - Field zero converts at once; reset value zero.
// - Sampling resumes right after every finished conversion.
// - Only the start bit shows sequencer progress.
// - Thirteen bit periods make one twelve-bit result.
// - Result formed by successive approximation on sample.
// - Conversion continues in sleep only on RC clock.
// - Port read returns zero on analog pins.
// - Selected channel converts whatever its pin setting.
package sas_pkg;

	// ************************************************************
	// Timing.
	// ************************************************************
	localparam int CLK_PERIOD_NS = 8;   // System clock period.
	localparam int TCY_NS        = 32;  // One instruction cycle, four oscillator periods.
	localparam int TCY_CYCLES    = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_PERIODS  = 13;  // Bit periods per conversion.

	// ************************************************************
	// Register byte offsets and reset values.
	// ************************************************************
	localparam logic [7:0] OFS_MAIN   = 8'h00; // adc_main_control.
	localparam logic [7:0] OFS_REFPIN = 8'h04; // adc_ref_and_pin_config.
	localparam logic [7:0] OFS_TIMING = 8'h08; // adc_timing_and_format.
	localparam logic [7:0] OFS_RES_HI = 8'h0C; // result_high.
	localparam logic [7:0] OFS_RES_LO = 8'h10; // result_low.
	localparam logic [7:0] OFS_STATUS = 8'h14; // conversion_done_flag.
	localparam logic [7:0] OFS_PORT   = 8'h18; // Masked port read, low byte.
	localparam logic [7:0] OFS_PORT_H = 8'h1C; // Masked port read, high nibble.
	localparam logic [7:0] RST_MAIN   = 8'h00;
	localparam logic [7:0] RST_REFPIN = 8'h00;
	localparam logic [7:0] RST_TIMING = 8'h00;

	// ************************************************************
	// Field positions.
	// ************************************************************
	localparam int MAIN_ON_BIT  = 0; // Converter powered.
	localparam int MAIN_GO_BIT  = 1; // Start/done.
	localparam int MAIN_CHS_LSB = 2; // channel_select, four bits.
	localparam int REF_LSB      = 4; // ref_select, two bits.
	localparam int PCFG_LSB     = 0; // pin_analog_config, four bits.
	localparam int JUST_BIT     = 7; // result_justify.
	localparam int ACQ_LSB      = 3; // acq_time_select, three bits.
	localparam int CS_LSB       = 0; // conv_clock_select, three bits.
	localparam int FLAG_BIT     = 0; // conversion_done_flag.

	// Acquisition lengths in bit periods, indexed by the field.
	localparam logic [4:0] ACQ_TABLE [0:7] = '{5'd0, 5'd2, 5'd4, 5'd6,
		5'd8, 5'd12, 5'd16, 5'd20};

	// Oscillator divisor per clock code; zero marks the RC clock.
	localparam logic [6:0] DIV_TABLE [0:7] = '{7'd2, 7'd8, 7'd32, 7'd0,
		7'd4, 7'd16, 7'd64, 7'd0};

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Signals towards the sample-and-hold and converter array.
	typedef struct packed {
		logic        sample;     // Hold capacitor tracks the input.
		logic [11:0] dac_code;   // Trial code for the comparator.
		logic        ref_hi_ext; // High reference from external pin.
		logic        ref_lo_ext; // Low reference from external pin.
		logic [3:0]  channel;    // Selected input.
	} sas_afe_s;

	typedef enum logic [1:0] {ST_SAMPLE, ST_RC_DLY, ST_ACQ, ST_CONV} sas_state_e;

endpackage

// ===== sas_tad_gen.sv
// Bit-period enable generator for the converter.
// Assumes rc_tick is a one-cycle pulse from the internal RC oscillator.
module sas_tad_gen
	import sas_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       run,       // Sequencer wants bit periods.
	input  wire logic       halt,      // Oscillator stopped by sleep.
	input  wire logic [2:0] clk_sel,   // conv_clock_select.
	input  wire logic       rc_tick,   // internal_rc_clock pulse.
	output logic            bit_tick   // One pulse per bit period.
);

	logic [6:0] cnt;      // Oscillator cycles into this period.
	wire  [6:0] divisor = DIV_TABLE[clk_sel];
	wire        rc_sel  = (divisor == 7'd0);
	wire        wrap    = (cnt == divisor - 7'd1);

	// ************************************************************
	// Divider.
	// ************************************************************
	// The count restarts whenever the sequencer pauses so that every
	// conversion begins on a full bit period.
	always_ff @(posedge clk)
	begin
		if (sys_rst || !run)
		begin
			cnt      <= 7'd0;
			bit_tick <= 1'b0;
		end
		else if (rc_sel)
		begin
			bit_tick <= rc_tick;
		end
		else if (halt)
		begin
			bit_tick <= 1'b0;
		end
		else
		begin
			cnt      <= wrap ? 7'd0 : cnt + 7'd1;
			bit_tick <= wrap;
		end
	end

endmodule

// ===== sas_sar.sv
// Successive-approximation register for the converter.
// Assumes cmp_above is high when the held sample is at or above dac_code.
module sas_sar
	import sas_pkg::*;
#(
	parameter int WIDTH = 12
)
(
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic             start,     // Begin a conversion.
	input  wire logic             abort,     // Drop the conversion.
	input  wire logic             bit_tick,  // One pulse per bit period.
	input  wire logic             cmp_above, // Comparator answer.
	output logic [WIDTH-1:0]      dac_code,  // Current trial code.
	output logic                  done,      // One-cycle completion pulse.
	output logic [WIDTH-1:0]      result     // Last finished result.
);

	// The step counter and the thirteen-period schedule serve twelve bits only.
	if (WIDTH != 12)
	begin : g_width_check
		$error("sas_sar serves only twelve-bit results");
	end

	logic       busy;  // Conversion under way.
	logic [3:0] step;  // Bit periods used so far.

	wire [3:0]       k     = 4'(WIDTH) - step;
	wire [WIDTH-1:0] trial = WIDTH'(1) << k;
	wire [WIDTH-1:0] kept  = cmp_above ? dac_code : (dac_code & ~trial);

	// ************************************************************
	// Approximation.
	// ************************************************************
	// Period zero sets the top trial; periods one to twelve each decide a
	// bit from the top down, thirteen periods in all.
	always_ff @(posedge clk)
	begin
		done <= 1'b0;
		if (sys_rst || abort)
		begin
			busy     <= 1'b0;
			step     <= 4'd0;
			dac_code <= '0;
			if (sys_rst)
				result <= '0;
		end
		else if (start)
		begin
			busy     <= 1'b1;
			step     <= 4'd0;
			dac_code <= '0;
		end
		else if (busy && bit_tick)
		begin
			step <= step + 4'd1;
			if (step == 4'd0)
				dac_code <= WIDTH'(1) << (WIDTH - 1);
			else if (step == 4'(CONV_PERIODS - 1))
			begin
				result <= kept;
				done   <= 1'b1;
				busy   <= 1'b0;
			end
			else
				dac_code <= kept | (trial >> 1);
		end
	end

endmodule

// ===== sas_top.sv
// Sequencer, register file and AXI4-Lite slave of the SAR converter.
// Assumes the analog side holds the sample while afe.sample is low and
// answers each trial code on cmp_above within one bit period.
module sas_top
	import sas_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// AXI4-Lite slave.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Device context.
	input  wire logic        sleep_mode,    // Core is asleep.
	input  wire logic        rc_tick,       // internal_rc_clock pulse.
	input  wire logic [11:0] port_pin_in,   // Digital input buffers.
	input  wire logic        cmp_above,     // Comparator answer.
	output sas_afe_s         afe,           // To the analog array.
	output logic [11:0]      pin_is_analog  // Per-input analog mode.
);

	// ************************************************************
	// Registers and state.
	// ************************************************************
	logic        adc_on;        // Converter powered.
	logic        go;            // Start/done bit.
	logic [3:0]  channel_select;
	logic [7:0]  adc_ref_and_pin_config;
	logic [7:0]  adc_timing_and_format;
	logic [7:0]  result_high;
	logic [7:0]  result_low;
	logic        conversion_done_flag;
	sas_state_e  state;
	logic [4:0]  acq_cnt;       // Bit periods of acquisition left.
	logic [2:0]  dly_cnt;       // Cycles of RC start delay left.
	logic        sar_start;     // Pulse into the approximation engine.
	logic        sar_abort;     // Pulse that drops a conversion.

	// AXI holding registers.
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [7:0]  w_data;
	logic        w_lane0;

	// ************************************************************
	// Field decode.
	// ************************************************************
	wire [1:0] ref_select        = adc_ref_and_pin_config[REF_LSB +: 2];
	wire [3:0] pin_analog_config = adc_ref_and_pin_config[PCFG_LSB +: 4];
	wire       result_justify    = adc_timing_and_format[JUST_BIT];
	wire [2:0] acq_time_select   = adc_timing_and_format[ACQ_LSB +: 3];
	wire [2:0] conv_clock_select = adc_timing_and_format[CS_LSB +: 3];
	wire [4:0] acq_periods       = ACQ_TABLE[acq_time_select];
	wire       rc_selected       = (DIV_TABLE[conv_clock_select] == 7'd0);

	// Inputs whose number is below fifteen minus the code stay analog;
	// codes up to three leave all twelve analog.
	wire [4:0] analog_limit = (pin_analog_config <= 4'd3) ? 5'd12
		: 5'd15 - {1'b0, pin_analog_config};
	wire [11:0] next_analog;

	genvar gi;
	generate
		for (gi = 0; gi < 12; gi++)
		begin : g_pin
			assign next_analog[gi] = (5'(gi) < analog_limit);
		end
	endgenerate

	// ************************************************************
	// Bus decode.
	// ************************************************************
	wire       wr_fire   = aw_held && w_held && !s_axi_bvalid;
	wire       wr_main   = wr_fire && w_lane0 && (aw_addr == OFS_MAIN);
	wire       wr_refpin = wr_fire && w_lane0 && (aw_addr == OFS_REFPIN);
	wire       wr_timing = wr_fire && w_lane0 && (aw_addr == OFS_TIMING);
	wire       wr_status = wr_fire && w_lane0 && (aw_addr == OFS_STATUS);
	wire       wr_known  = (aw_addr == OFS_MAIN) || (aw_addr == OFS_REFPIN)
		|| (aw_addr == OFS_TIMING) || (aw_addr == OFS_STATUS)
		|| (aw_addr == OFS_RES_HI) || (aw_addr == OFS_RES_LO)
		|| (aw_addr == OFS_PORT) || (aw_addr == OFS_PORT_H);
	wire       go_write  = wr_main && w_data[MAIN_GO_BIT];
	wire       start_req = go_write && !go && adc_on;
	// Clearing the start bit or switching off drops a running conversion.
	wire       stop_req  = wr_main && go
		&& (!w_data[MAIN_GO_BIT] || !w_data[MAIN_ON_BIT]);

	// Analog pins read as zero in the port view.
	wire [11:0] port_view = port_pin_in & ~pin_is_analog;

	// Only the start bit tells software where the sequencer is.
	wire [7:0] main_view = {2'b00, channel_select, go, adc_on};
	wire       rd_known;
	wire [7:0] rd_byte =
		(s_axi_araddr == OFS_MAIN)   ? main_view :
		(s_axi_araddr == OFS_REFPIN) ? (adc_ref_and_pin_config & 8'h3F) :
		(s_axi_araddr == OFS_TIMING) ? (adc_timing_and_format & 8'hBF) :
		(s_axi_araddr == OFS_RES_HI) ? result_high :
		(s_axi_araddr == OFS_RES_LO) ? result_low :
		(s_axi_araddr == OFS_STATUS) ? {7'h00, conversion_done_flag} :
		(s_axi_araddr == OFS_PORT)   ? port_view[7:0] :
		(s_axi_araddr == OFS_PORT_H) ? {4'h0, port_view[11:8]} : 8'h00;
	assign rd_known = (s_axi_araddr == OFS_MAIN) || (s_axi_araddr == OFS_REFPIN)
		|| (s_axi_araddr == OFS_TIMING) || (s_axi_araddr == OFS_RES_HI)
		|| (s_axi_araddr == OFS_RES_LO) || (s_axi_araddr == OFS_STATUS)
		|| (s_axi_araddr == OFS_PORT) || (s_axi_araddr == OFS_PORT_H);

	// ************************************************************
	// Converter engines.
	// ************************************************************
	wire        tad_run = (state == ST_ACQ) || (state == ST_CONV);
	// Without the RC clock the oscillator stops in sleep and so do we.
	wire        tad_halt = sleep_mode && !rc_selected;
	wire        bit_tick;
	wire        sar_done;
	wire [11:0] sar_code;
	wire [11:0] sar_result;

	sas_tad_gen u_tad (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.run      (tad_run),
		.halt     (tad_halt),
		.clk_sel  (conv_clock_select),
		.rc_tick  (rc_tick),
		.bit_tick (bit_tick)
	);

	sas_sar #(.WIDTH(12)) u_sar (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.start     (sar_start),
		.abort     (sar_abort),
		.bit_tick  (bit_tick),
		.cmp_above (cmp_above),
		.dac_code  (sar_code),
		.done      (sar_done),
		.result    (sar_result)
	);

	// Justified result pair.
	wire [7:0] next_res_hi = result_justify ? {4'h0, sar_result[11:8]}
		: sar_result[11:4];
	wire [7:0] next_res_lo = result_justify ? sar_result[7:0]
		: {sar_result[3:0], 4'h0};

	// ************************************************************
	// Sequencer.
	// ************************************************************
	// A start goes through the RC delay when that clock is chosen, then
	// through acquisition when one is programmed, then into conversion.
	wire after_dly_acq = (acq_periods != 5'd0);

	always_ff @(posedge clk)
	begin
		sar_start <= 1'b0;
		sar_abort <= 1'b0;
		if (sys_rst)
		begin
			state   <= ST_SAMPLE;
			acq_cnt <= 5'd0;
			dly_cnt <= 3'd0;
		end
		else if (stop_req)
		begin
			state     <= ST_SAMPLE;
			sar_abort <= 1'b1;
		end
		else
		begin
			case (state)
				ST_SAMPLE:
				begin
					if (start_req && rc_selected)
					begin
						state   <= ST_RC_DLY;
						dly_cnt <= 3'(TCY_CYCLES - 1);
					end
					else if (start_req && after_dly_acq)
					begin
						state   <= ST_ACQ;
						acq_cnt <= acq_periods;
					end
					else if (start_req)
					begin
						state     <= ST_CONV;
						sar_start <= 1'b1;
					end
				end
				ST_RC_DLY:
				begin
					if (dly_cnt != 3'd0)
						dly_cnt <= dly_cnt - 3'd1;
					else if (after_dly_acq)
					begin
						state   <= ST_ACQ;
						acq_cnt <= acq_periods;
					end
					else
					begin
						state     <= ST_CONV;
						sar_start <= 1'b1;
					end
				end
				ST_ACQ:
				begin
					if (bit_tick && acq_cnt == 5'd1)
					begin
						state     <= ST_CONV;
						sar_start <= 1'b1;
					end
					else if (bit_tick)
						acq_cnt <= acq_cnt - 5'd1;
				end
				ST_CONV:
				begin
					if (sar_done)
						state <= ST_SAMPLE;
				end
				default:
					state <= ST_SAMPLE;
			endcase
		end
	end

	// ************************************************************
	// Control registers.
	// ************************************************************
	// The start bit stays set from the write until done or abort.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			adc_on                 <= RST_MAIN[MAIN_ON_BIT];
			go                     <= RST_MAIN[MAIN_GO_BIT];
			channel_select         <= RST_MAIN[MAIN_CHS_LSB +: 4];
			adc_ref_and_pin_config <= RST_REFPIN;
			adc_timing_and_format  <= RST_TIMING;
		end
		else
		begin
			if (wr_main)
			begin
				adc_on         <= w_data[MAIN_ON_BIT];
				channel_select <= w_data[MAIN_CHS_LSB +: 4];
			end
			if (sar_done && state == ST_CONV)
				go <= 1'b0;
			else if (stop_req)
				go <= 1'b0;
			else if (start_req)
				go <= 1'b1;
			if (wr_refpin)
				adc_ref_and_pin_config <= w_data;
			if (wr_timing)
				adc_timing_and_format <= w_data;
		end
	end

	// Completion loads the pair and raises the flag; a completion in the
	// same cycle as a software clear keeps the flag set.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			result_high          <= 8'h00;
			result_low           <= 8'h00;
			conversion_done_flag <= 1'b0;
		end
		else if (sar_done && state == ST_CONV)
		begin
			result_high          <= next_res_hi;
			result_low           <= next_res_lo;
			conversion_done_flag <= 1'b1;
		end
		else if (wr_status && w_data[FLAG_BIT])
			conversion_done_flag <= 1'b0;
	end

	// ************************************************************
	// Analog outputs.
	// ************************************************************
	// The channel goes out unmasked: a digital or driven pin converts too.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			afe           <= '0;
			pin_is_analog <= 12'hFFF;
		end
		else
		begin
			afe.sample     <= adc_on && !(state == ST_CONV);
			afe.dac_code   <= sar_code;
			afe.ref_hi_ext <= ref_select[0];
			afe.ref_lo_ext <= ref_select[1];
			afe.channel    <= channel_select;
			pin_is_analog  <= next_analog;
		end
	end

	// ************************************************************
	// AXI4-Lite write channel.
	// ************************************************************
	// Address and data are taken in either order and answered together.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 8'h00;
			w_lane0       <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held       <= 1'b1;
				aw_addr       <= {s_axi_awaddr[7:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held       <= 1'b1;
				w_data       <= s_axi_wdata[7:0];
				w_lane0      <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (wr_fire)
			begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ************************************************************
	// AXI4-Lite read channel.
	// ************************************************************
	// One read at a time; the address is refused while data waits.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h00_0000, rd_byte};
			s_axi_rresp   <= rd_known ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule

// ===== sas_top_props.sv
// Port-level checks for the converter sequencer top level.
// Assumes binding to sas_top with its single clock and reset.
module sas_top_props
	import sas_pkg::*;
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire sas_afe_s    afe,
	input wire logic [11:0] pin_is_analog
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// ********************
	// Helper logic.
	// ********************
	logic [7:0] ar_q;  // Address of the read under way, since rdata carries none.
	always_ff @(posedge clk)
		if (s_axi_arvalid && s_axi_arready)
			ar_q <= s_axi_araddr;
	// Expected analog mask for a pin code: inputs turn digital from the top.
	function automatic logic [11:0] amap(input logic [3:0] c);
		return 12'hFFF >> ((c < 4'h4) ? 0 : c - 4'h3);
	endfunction
	// ********************
	// Assertions.
	// ********************
	wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid) else $error("write answer late");
	rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer changed");
	rst_state_a: assert property (disable iff (1'b0) sys_rst |=>
		pin_is_analog == 12'hFFF && !afe.sample && afe.dac_code == 12'h000)
		else $error("reset state wrong");
	port_mask_a: assert property (s_axi_rvalid && ar_q[7:3] == 5'h03 |->
		(s_axi_rdata[7:0] & (ar_q[2] ? {4'h0, pin_is_analog[11:8]} : pin_is_analog[7:0])) == 8'h00)
		else $error("analog pin read nonzero");
	ref_out_a: assert property (s_axi_rvalid && ar_q[7:2] == 6'h01 |->
		afe.ref_hi_ext == s_axi_rdata[4] && afe.ref_lo_ext == s_axi_rdata[5])
		else $error("reference select wrong");
	pin_map_a: assert property (s_axi_rvalid && ar_q[7:2] == 6'h01 |->
		pin_is_analog == amap(s_axi_rdata[3:0])) else $error("pin mask wrong");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property ($fell(afe.sample));
	cover property ($rose(afe.sample));
endmodule
bind sas_top sas_top_props i_props (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .afe, .pin_is_analog);

// ===== tb_sar_adc_sequencer.sv
// Self-checking bench for the converter sequencer over AXI4-Lite.
// Assumes sas_top; the comparator model converts a fixed input of 12'hA5C.
module tb_sar_adc_sequencer
	import sas_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic sleep_mode, rc_tick, cmp_above, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rv;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, br;
	logic [11:0] port_pin_in, pin_is_analog, e;
	sas_afe_s    afe;
	int          cyc, failures, num_checks, i;
	logic [23:0] rows [4] = '{24'h04_35_35, 24'h04_FF_3F, 24'h08_FF_BF, 24'h08_00_00};
	sas_top i_dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .sleep_mode, .rc_tick, .port_pin_in, .cmp_above, .afe, .pin_is_analog);
	always #4 clk = ~clk;
	// Cycle count, RC pulse every fifth cycle, comparator answering one cycle late.
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		rc_tick <= (cyc % 5 == 0);
		cmp_above <= (12'hA5C >= afe.dac_code);
	end
	task automatic final_report();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		num_checks++;
		if (s !== x)
		begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, s, x);
		end
	endtask
	// Write one word; address and data are offered together, each released when taken.
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && !s_axi_bvalid; n++)
		begin
			@(posedge clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n == 50)
			chk(32'h0, 32'h1);
		if (n == 50)
			final_report();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		int n;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && !s_axi_rvalid; n++)
		begin
			@(posedge clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		d = s_axi_rdata;
		chk({30'h0, s_axi_rresp}, {30'h0, RESP_OKAY});
		s_axi_rready <= 1'b0;
		if (n == 50)
			chk(32'h0, 32'h1);
		if (n == 50)
			final_report();
	endtask
	// Poll start/done until it clears and check the elapsed cycles.
	task automatic wgo(input int lo, input int hi);
		int t0;
		int n;
		t0 = cyc;
		rv = 32'h2;
		for (n = 0; n < 500 && rv[1]; n++)
			rd(8'h00, rv);
		chk(32'(cyc - t0 >= lo && cyc - t0 <= hi), 32'h1);
	endtask
	task automatic conv(input logic [7:0] tm, input int lo, input int hi);
		wr(8'h08, tm, br);
		wr(8'h00, 8'h03, br);
		wgo(lo, hi);
	endtask
	initial
	begin
		{clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{sleep_mode, failures, num_checks} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		port_pin_in = 12'hFFF;
		sys_rst = 1'b1;
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		for (i = 0; i < 3; i++)
		begin
			rd(8'(i * 4), rv);
			chk(rv, 32'h0);
		end
		for (i = 0; i < 4; i++)
		begin
			wr(rows[i][23:16], rows[i][15:8], br);
			rd(rows[i][23:16], rv);
			chk(rv, {24'h0, rows[i][7:0]});
		end
		$display("test registers done");
		for (i = 0; i < 16; i++)
		begin
			wr(8'h04, {2'b00, i[1:0], i[3:0]}, br);
			e = (i < 4) ? 12'hFFF : 12'hFFF >> (i - 3);
			repeat (2) @(posedge clk);
			chk({20'h0, pin_is_analog}, {20'h0, e});
			chk({30'h0, afe.ref_lo_ext, afe.ref_hi_ext}, {30'h0, i[1:0]});
		end
		wr(8'h04, 8'h0A, br);
		rd(8'h18, rv);
		chk(rv, 32'hE0);
		rd(8'h1C, rv);
		chk(rv, 32'h0F);
		wr(8'h40, 8'h00, br);
		chk({30'h0, br}, {30'h0, RESP_SLVERR});
		$display("test pins done");
		wr(8'h00, 8'h29, br);
		repeat (2) @(posedge clk);
		chk({28'h0, afe.channel}, 32'hA);
		conv(8'h81, 100, 112);
		chk({31'h0, afe.sample}, 32'h1);
		rd(8'h0C, rv);
		chk(rv, 32'h0A);
		rd(8'h10, rv);
		chk(rv, 32'h5C);
		rd(8'h14, rv);
		chk(rv, 32'h1);
		wr(8'h14, 8'h01, br);
		conv(8'h39, 260, 272);
		rd(8'h0C, rv);
		chk(rv, 32'hA5);
		rd(8'h10, rv);
		chk(rv, 32'hC0);
		$display("test conversion done");
		@(posedge clk) sleep_mode <= 1'b1;
		conv(8'h83, 62, 82);
		wr(8'h08, 8'h81, br);
		wr(8'h00, 8'h03, br);
		repeat (300) @(posedge clk);
		rd(8'h00, rv);
		chk(rv, 32'h3);
		chk({31'h0, afe.sample}, 32'h0);
		sleep_mode <= 1'b0;
		wgo(100, 112);
		wr(8'h14, 8'h01, br);
		wr(8'h08, 8'h3E, br);
		wr(8'h00, 8'h03, br);
		rd(8'h00, rv);
		chk(rv, 32'h3);
		wr(8'h00, 8'h01, br);
		rd(8'h00, rv);
		chk(rv, 32'h1);
		rd(8'h14, rv);
		chk(rv, 32'h0);
		wr(8'h00, 8'h03, br);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(8'h00, rv);
		chk(rv, 32'h0);
		rd(8'h08, rv);
		chk(rv, 32'h0);
		$display("test sleep abort reset done");
		final_report();
	end
endmodule
